// ---- core/twb_pkg.sv ----
package twb_pkg;

	// ****************************************
	// bit positions and counts
	// ****************************************
	localparam logic [3:0] TWB_LAST_BIT = 4'h7;
	localparam logic [3:0] TWB_ACK_BIT = 4'h8;
	localparam logic [7:0] TWB_CNT_ZERO = 8'h00;
	localparam logic [2:0] TWB_LINE_IDLE = 3'h7;
	localparam int TWB_DEV_HALF = 25;
	localparam int TWB_HOST_HALF = 50;

	// ****************************************
	// slave addresses answered by the device
	// ****************************************
	localparam logic [6:0] TWB_SLV_ADDR0 = 7'h2a;
	localparam logic [6:0] TWB_SLV_ADDR1 = 7'h2b;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {TWB_OP_START, TWB_OP_WRITE, TWB_OP_READ, TWB_OP_STOP} twb_op_t;
	typedef enum logic [2:0] {SP_IDLE, SP_ADDR, SP_RX, SP_TX, SP_SKIP} twb_slv_ph_t;
	typedef enum logic [2:0] {
		MS_IDLE, MS_START, MS_LOW, MS_HIGH, MS_PLOW, MS_PHIGH, MS_PEND, MS_LOST
	} twb_mst_st_t;
	typedef enum logic [3:0] {
		HS_WAIT, HS_RS1, HS_RS2, HS_ST, HS_LOW, HS_HIGH, HS_PLOW, HS_PHIGH, HS_PEND, HS_LOST
	} twb_host_st_t;

	// toggle event seen between second and third flop
	function automatic logic twb_evt(input logic [2:0] s);
		return s[2] ^ s[1];
	endfunction

endpackage

// ---- core/twb_bus_if.sv ----
`timescale 1ns/1ns
interface twb_bus_if;
	logic dev_scl_o;
	logic dev_scl_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic scl;
	logic sda;

	// wired-and lines, pulled high when released
	assign scl = ~((dev_scl_oe & ~dev_scl_o) | (host_scl_oe & ~host_scl_o));
	assign sda = ~((dev_sda_oe & ~dev_sda_o) | (host_sda_oe & ~host_sda_o));

	modport dev (output dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe, input scl, sda);
	modport host (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe, input scl, sda);
endinterface

// ---- core/twb_dev_end.sv ----
`timescale 1ns/1ns
// Contract
// - lines only pulled low or released
// - start is sda fall, scl high
// - stop is sda rise, scl high
// - start while busy is repeated start
// - sda changes only while scl low
// - eight bits msb first, then ack
// - ack low on ninth clock, nack released
// - start followed by address and direction
// - matching slave acks, others stay released
// - master and two slave addresses
// - one address packet per start
// - direction zero write, one read
// - unlimited nine-bit data packets follow address
// - master stops after nack or no data
// - master reader nacks last byte only
// - repeated start chains transfers
// - stretch scl only after seeing low
// - wait while scl held low
// - slave stretches only around ack
// - master starts only on idle bus
// - lost arbitration releases, waits for stop
// - start/stop contests left to software
module twb_dev_end
	import twb_pkg::*;
#(
	parameter int HALF = TWB_DEV_HALF,
	parameter logic [6:0] SLV_ADDR0 = TWB_SLV_ADDR0,
	parameter logic [6:0] SLV_ADDR1 = TWB_SLV_ADDR1
)(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic link_clk,
	twb_bus_if.dev bus,
	output logic [7:0] slv_rx_data,
	output logic slv_rx_valid,
	output logic slv_tx_need,
	input wire logic [7:0] slv_tx_data,
	input wire logic slv_tx_valid,
	input wire logic mst_start,
	input wire logic [6:0] mst_addr,
	input wire logic [7:0] mst_data,
	output logic mst_busy,
	output logic mst_done,
	output logic mst_nack,
	output logic mst_arb_lost
);
	if (HALF < 2 || HALF > 255) begin : g_bad_half
		$error("HALF out of range");
	end
	localparam logic [7:0] HALF_C = 8'(HALF);

	// ****************************************
	// declarations
	// ****************************************
	logic [1:0] lrst;
	logic [2:0] scl_sy;
	logic [2:0] sda_sy;
	logic busy;
	twb_slv_ph_t sph;
	logic [3:0] sbit;
	logic [7:0] srx;
	logic [7:0] stx;
	logic s_rw;
	logic s_mnack;
	logic s_sda_low;
	logic s_scl_low;
	logic s_txl;
	logic rx_tgl;
	logic [7:0] rx_byte;
	logic tq_tgl;
	logic [1:0] rxa_sy;
	logic [1:0] ta_sy;
	logic [2:0] mq_sy;
	twb_mst_st_t mst;
	logic [7:0] mcnt;
	logic [3:0] mbit;
	logic mbyte;
	logic [7:0] msh;
	logic m_sda_low;
	logic m_scl_low;
	logic m_seen;
	logic m_ack_n;
	logic m_req;
	logic res_nack;
	logic res_lost;
	logic md_tgl;
	logic [2:0] rx_sy;
	logic [2:0] tq_sy;
	logic [2:0] md_sy;
	logic rxa_tgl;
	logic ta_tgl;
	logic mq_tgl;
	logic [7:0] tx_hold;
	logic [6:0] cmd_addr;
	logic [7:0] cmd_data;

	// ****************************************
	// link domain reset and line sampling
	// ****************************************
	wire link_rst_b = lrst[1];
	wire scl_s = scl_sy[1];
	wire sda_s = sda_sy[1];
	wire scl_rise = scl_s & ~scl_sy[2];
	wire scl_fall = ~scl_s & scl_sy[2];
	wire start_c = scl_s & scl_sy[2] & sda_sy[2] & ~sda_s;
	wire stop_c = scl_s & scl_sy[2] & ~sda_sy[2] & sda_s;
	wire addr_hit = (srx[7:1] == SLV_ADDR0) | (srx[7:1] == SLV_ADDR1);
	wire rx_done = ~(rx_tgl ^ rxa_sy[1]);
	wire tx_done = ~(tq_tgl ^ ta_sy[1]);
	wire m_end = mcnt == HALF_C;
	wire [7:0] mcnt_inc = mcnt + 8'h01;

	// open-drain drive, output value always low
	assign bus.dev_scl_o = 1'b0;
	assign bus.dev_sda_o = 1'b0;
	assign bus.dev_scl_oe = s_scl_low | m_scl_low;
	assign bus.dev_sda_oe = s_sda_low | m_sda_low;

	// reset release synchroniser for the link domain
	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			lrst <= 2'h0;
		end else begin
			lrst <= {lrst[0], 1'b1};
		end
	end

	// two-flop line sync plus one history flop
	always_ff @(posedge link_clk or negedge link_rst_b) begin
		if (!link_rst_b) begin
			scl_sy <= TWB_LINE_IDLE;
			sda_sy <= TWB_LINE_IDLE;
			rxa_sy <= 2'h0;
			ta_sy <= 2'h0;
			mq_sy <= 3'h0;
			busy <= 1'b0;
		end else begin
			scl_sy <= {scl_sy[1:0], bus.scl};
			sda_sy <= {sda_sy[1:0], bus.sda};
			rxa_sy <= {rxa_sy[0], rxa_tgl};
			ta_sy <= {ta_sy[0], ta_tgl};
			mq_sy <= {mq_sy[1:0], mq_tgl};
			if (start_c) begin
				busy <= 1'b1;
			end else if (stop_c) begin
				busy <= 1'b0;
			end
		end
	end

	// ****************************************
	// slave engine
	// ****************************************
	always_ff @(posedge link_clk or negedge link_rst_b) begin
		if (!link_rst_b) begin
			sph <= SP_IDLE;
			sbit <= 4'h0;
			srx <= 8'h00;
			stx <= 8'h00;
			s_rw <= 1'b0;
			s_mnack <= 1'b0;
			s_sda_low <= 1'b0;
			s_scl_low <= 1'b0;
			s_txl <= 1'b0;
			rx_tgl <= 1'b0;
			rx_byte <= 8'h00;
			tq_tgl <= 1'b0;
		end else if (start_c) begin
			// first and repeated start alike open a new address packet
			sph <= SP_ADDR;
			sbit <= 4'hf; // start hold fall wraps this to bit 0
			s_sda_low <= 1'b0;
		end else if (stop_c) begin
			sph <= SP_IDLE;
			s_sda_low <= 1'b0;
		end else begin
			if (scl_rise && sbit != TWB_ACK_BIT && (sph == SP_ADDR || sph == SP_RX)) begin
				srx <= {srx[6:0], sda_s}; // msb first
			end
			if (scl_rise && sbit == TWB_ACK_BIT && sph == SP_TX) begin
				s_mnack <= sda_s;
			end
			if (scl_fall) begin
				if (sbit == TWB_LAST_BIT) begin
					sbit <= TWB_ACK_BIT;
					case (sph)
						SP_ADDR: begin
							if (addr_hit) begin
								s_sda_low <= 1'b1;
								s_rw <= srx[0];
							end else begin
								sph <= SP_SKIP;
							end
						end
						SP_RX: begin
							s_scl_low <= 1'b1; // line seen low, stretch before ack
							rx_byte <= srx;
							rx_tgl <= ~rx_tgl;
						end
						SP_TX: begin
							s_sda_low <= 1'b0;
						end
						default: begin
						end
					endcase
				end else if (sbit == TWB_ACK_BIT) begin
					sbit <= 4'h0;
					s_sda_low <= 1'b0;
					if (sph == SP_ADDR) begin
						sph <= s_rw ? SP_TX : SP_RX;
					end else if (sph == SP_TX && s_mnack) begin
						sph <= SP_SKIP; // reader nacked its last byte
					end
					if ((sph == SP_ADDR && s_rw) || (sph == SP_TX && !s_mnack)) begin
						s_scl_low <= 1'b1; // stretch after ack for next byte
						tq_tgl <= ~tq_tgl;
					end
				end else begin
					sbit <= sbit + 4'h1;
					if (sph == SP_TX) begin
						s_sda_low <= ~stx[7]; // change while scl low
						stx <= {stx[6:0], 1'b0};
					end
				end
			end
			// rx stretch: ack first, release clock one cycle later
			if (s_scl_low && sph == SP_RX && sbit == TWB_ACK_BIT && rx_done) begin
				if (!s_sda_low) begin
					s_sda_low <= 1'b1;
				end else begin
					s_scl_low <= 1'b0;
				end
			end
			// tx stretch: first bit out, then release clock
			if (s_scl_low && sph == SP_TX && sbit == 4'h0 && tx_done) begin
				if (!s_txl) begin
					s_sda_low <= ~tx_hold[7];
					stx <= {tx_hold[6:0], 1'b0};
					s_txl <= 1'b1;
				end else begin
					s_scl_low <= 1'b0;
					s_txl <= 1'b0;
				end
			end
		end
	end

	// ****************************************
	// master engine, one address and one data byte
	// ****************************************
	always_ff @(posedge link_clk or negedge link_rst_b) begin
		if (!link_rst_b) begin
			mst <= MS_IDLE;
			mcnt <= TWB_CNT_ZERO;
			mbit <= 4'h0;
			mbyte <= 1'b0;
			msh <= 8'h00;
			m_sda_low <= 1'b0;
			m_scl_low <= 1'b0;
			m_seen <= 1'b0;
			m_ack_n <= 1'b0;
			m_req <= 1'b0;
			res_nack <= 1'b0;
			res_lost <= 1'b0;
			md_tgl <= 1'b0;
		end else begin
			if (twb_evt(mq_sy)) begin
				m_req <= 1'b1;
			end
			case (mst)
				MS_IDLE: begin
					mcnt <= TWB_CNT_ZERO;
					if (m_req && !busy) begin
						m_req <= 1'b0; // only on an idle bus
						res_nack <= 1'b0;
						res_lost <= 1'b0;
						m_sda_low <= 1'b1; // sda falls, scl high
						mst <= MS_START;
					end
				end
				MS_START: begin
					mcnt <= mcnt_inc;
					if (m_end) begin
						mcnt <= TWB_CNT_ZERO;
						m_scl_low <= 1'b1;
						mbit <= 4'h0;
						mbyte <= 1'b0;
						msh <= {cmd_addr, 1'b0}; // address then write bit
						mst <= MS_LOW;
					end
				end
				MS_LOW: begin
					mcnt <= mcnt_inc;
					if (mcnt == TWB_CNT_ZERO) begin
						m_sda_low <= (mbit != TWB_ACK_BIT) & ~msh[7];
					end
					if (m_end) begin
						mcnt <= TWB_CNT_ZERO;
						m_scl_low <= 1'b0;
						m_seen <= 1'b0;
						mst <= MS_HIGH;
					end
				end
				MS_HIGH: begin
					if (scl_s) begin // hold while another party stretches
						m_seen <= 1'b1;
						mcnt <= mcnt_inc;
						if (!m_seen && mbit == TWB_ACK_BIT) begin
							m_ack_n <= sda_s;
						end
						if (!m_seen && mbit != TWB_ACK_BIT && !m_sda_low && !sda_s) begin
							m_sda_low <= 1'b0;
							res_lost <= 1'b1;
							mst <= MS_LOST;
						end else if (m_end) begin
							mcnt <= TWB_CNT_ZERO;
							m_scl_low <= 1'b1;
							if (mbit != TWB_ACK_BIT) begin
								mbit <= mbit + 4'h1;
								msh <= {msh[6:0], 1'b0};
								mst <= MS_LOW;
							end else if (!m_ack_n && !mbyte) begin
								mbyte <= 1'b1;
								mbit <= 4'h0;
								msh <= cmd_data;
								mst <= MS_LOW;
							end else begin
								res_nack <= m_ack_n; // stop on nack or done
								mst <= MS_PLOW;
							end
						end
					end
				end
				MS_PLOW: begin
					mcnt <= mcnt_inc;
					if (mcnt == TWB_CNT_ZERO) begin
						m_sda_low <= 1'b1;
					end
					if (m_end) begin
						mcnt <= TWB_CNT_ZERO;
						m_scl_low <= 1'b0;
						mst <= MS_PHIGH;
					end
				end
				MS_PHIGH: begin
					if (scl_s) begin
						mcnt <= mcnt_inc;
					end
					if (scl_s && m_end) begin
						mcnt <= TWB_CNT_ZERO;
						m_sda_low <= 1'b0; // sda rises, scl high
						mst <= MS_PEND;
					end
				end
				MS_PEND: begin
					mcnt <= mcnt_inc;
					if (m_end) begin
						md_tgl <= ~md_tgl;
						mst <= MS_IDLE;
					end
				end
				MS_LOST: begin
					// winner keeps the bus until its stop
					if (!busy) begin
						md_tgl <= ~md_tgl;
						mst <= MS_IDLE;
					end
				end
				default: begin
					mst <= MS_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// user clock domain
	// ****************************************
	assign mst_busy = mq_tgl ^ md_sy[2];

	// handshake syncs and user side registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_sy <= 3'h0;
			tq_sy <= 3'h0;
			md_sy <= 3'h0;
			rxa_tgl <= 1'b0;
			ta_tgl <= 1'b0;
			mq_tgl <= 1'b0;
			tx_hold <= 8'h00;
			cmd_addr <= 7'h00;
			cmd_data <= 8'h00;
			slv_rx_data <= 8'h00;
			slv_rx_valid <= 1'b0;
			slv_tx_need <= 1'b0;
			mst_done <= 1'b0;
			mst_nack <= 1'b0;
			mst_arb_lost <= 1'b0;
		end else begin
			rx_sy <= {rx_sy[1:0], rx_tgl};
			tq_sy <= {tq_sy[1:0], tq_tgl};
			md_sy <= {md_sy[1:0], md_tgl};
			slv_rx_valid <= twb_evt(rx_sy);
			mst_done <= twb_evt(md_sy);
			if (twb_evt(rx_sy)) begin
				slv_rx_data <= rx_byte;
				rxa_tgl <= ~rxa_tgl;
			end
			if (twb_evt(tq_sy)) begin
				slv_tx_need <= 1'b1;
			end else if (slv_tx_valid && slv_tx_need) begin
				tx_hold <= slv_tx_data;
				slv_tx_need <= 1'b0;
				ta_tgl <= ~ta_tgl;
			end
			if (mst_start && !mst_busy) begin
				cmd_addr <= mst_addr;
				cmd_data <= mst_data;
				mq_tgl <= ~mq_tgl;
			end
			if (twb_evt(md_sy)) begin
				mst_nack <= res_nack;
				mst_arb_lost <= res_lost;
			end
		end
	end
endmodule // twb_dev_end

// ---- core/twb_host_end.sv ----
`timescale 1ns/1ns
module twb_host_end
	import twb_pkg::*;
#(
	parameter int HALF = TWB_HOST_HALF
)(
	input wire logic clk,
	input wire logic rst_b,
	twb_bus_if.host bus,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire twb_op_t cmd_op,
	input wire logic [7:0] cmd_data,
	input wire logic cmd_last,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_nack,
	output logic rsp_arb_lost,
	output logic bus_busy
);
	if (HALF < 2 || HALF > 255) begin : g_bad_half
		$error("HALF out of range");
	end
	localparam logic [7:0] HALF_C = 8'(HALF);

	// ****************************************
	// declarations and line sampling
	// ****************************************
	logic [2:0] scl_sy;
	logic [2:0] sda_sy;
	twb_host_st_t hst;
	logic [7:0] cnt;
	logic [3:0] hbit;
	logic [7:0] tsh;
	logic [7:0] rsh;
	logic h_tx;
	logic h_last;
	logic own;
	logic seen;
	logic ack_n;
	logic sda_low;
	logic scl_low;

	wire scl_s = scl_sy[1];
	wire sda_s = sda_sy[1];
	wire start_c = scl_s & scl_sy[2] & sda_sy[2] & ~sda_s;
	wire stop_c = scl_s & scl_sy[2] & ~sda_sy[2] & sda_s;
	wire c_end = cnt == HALF_C;
	wire [7:0] cnt_inc = cnt + 8'h01;
	wire take = cmd_valid & cmd_ready;

	assign cmd_ready = (hst == HS_WAIT) & (own | ~bus_busy);
	assign bus.host_scl_o = 1'b0;
	assign bus.host_sda_o = 1'b0;
	assign bus.host_scl_oe = scl_low;
	assign bus.host_sda_oe = sda_low;

	// line sync and bus busy monitor
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_sy <= TWB_LINE_IDLE;
			sda_sy <= TWB_LINE_IDLE;
			bus_busy <= 1'b0;
		end else begin
			scl_sy <= {scl_sy[1:0], bus.scl};
			sda_sy <= {sda_sy[1:0], bus.sda};
			if (start_c) begin
				bus_busy <= 1'b1;
			end else if (stop_c) begin
				bus_busy <= 1'b0;
			end
		end
	end

	// ****************************************
	// byte level master, scl made by divider
	// ****************************************
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hst <= HS_WAIT;
			cnt <= TWB_CNT_ZERO;
			hbit <= 4'h0;
			tsh <= 8'h00;
			rsh <= 8'h00;
			h_tx <= 1'b0;
			h_last <= 1'b0;
			own <= 1'b0;
			seen <= 1'b0;
			ack_n <= 1'b0;
			sda_low <= 1'b0;
			scl_low <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data <= 8'h00;
			rsp_nack <= 1'b0;
			rsp_arb_lost <= 1'b0;
		end else begin
			rsp_valid <= 1'b0;
			case (hst)
				HS_WAIT: begin
					cnt <= TWB_CNT_ZERO;
					scl_low <= own; // byte level stretch, line already low
					hbit <= 4'h0;
					if (take) begin
						tsh <= cmd_data;
						h_tx <= cmd_op != TWB_OP_READ;
						h_last <= cmd_last;
						rsp_arb_lost <= 1'b0;
						if (cmd_op == TWB_OP_START) begin
							hst <= own ? HS_RS1 : HS_ST; // repeated start
						end else if (!own) begin
							rsp_valid <= 1'b1; // refused when not owning
							rsp_nack <= 1'b1;
						end else if (cmd_op == TWB_OP_STOP) begin
							hst <= HS_PLOW;
						end else begin
							hst <= HS_LOW;
						end
					end
				end
				HS_RS1: begin
					cnt <= cnt_inc;
					sda_low <= 1'b0;
					if (c_end) begin
						cnt <= TWB_CNT_ZERO;
						scl_low <= 1'b0;
						hst <= HS_RS2;
					end
				end
				HS_RS2: begin
					if (scl_s) begin
						cnt <= cnt_inc;
					end
					if (scl_s && c_end) begin
						cnt <= TWB_CNT_ZERO;
						hst <= HS_ST;
					end
				end
				HS_ST: begin
					cnt <= cnt_inc;
					sda_low <= 1'b1; // sda falls, scl high
					if (c_end) begin
						cnt <= TWB_CNT_ZERO;
						scl_low <= 1'b1;
						own <= 1'b1;
						hst <= HS_LOW; // address byte follows
					end
				end
				HS_LOW: begin
					cnt <= cnt_inc;
					if (cnt == TWB_CNT_ZERO) begin
						// data msb first, ack low on reads except the last read
						sda_low <= (hbit != TWB_ACK_BIT) ? (h_tx & ~tsh[7]) : (~h_tx & ~h_last);
					end
					if (c_end) begin
						cnt <= TWB_CNT_ZERO;
						scl_low <= 1'b0;
						seen <= 1'b0;
						hst <= HS_HIGH;
					end
				end
				HS_HIGH: begin
					if (scl_s) begin // wait out stretching
						seen <= 1'b1;
						cnt <= cnt_inc;
						if (!seen && hbit == TWB_ACK_BIT) begin
							ack_n <= sda_s & h_tx;
						end
						if (!seen && hbit != TWB_ACK_BIT && !h_tx) begin
							rsh <= {rsh[6:0], sda_s};
						end
						// only data bits are contested here
						if (!seen && hbit != TWB_ACK_BIT && h_tx && !sda_low && !sda_s) begin
							sda_low <= 1'b0;
							rsp_arb_lost <= 1'b1;
							hst <= HS_LOST;
						end else if (c_end) begin
							cnt <= TWB_CNT_ZERO;
							scl_low <= 1'b1;
							if (hbit != TWB_ACK_BIT) begin
								hbit <= hbit + 4'h1;
								tsh <= {tsh[6:0], 1'b0};
								hst <= HS_LOW;
							end else begin
								rsp_valid <= 1'b1; // user issues stop after nack
								rsp_data <= rsh;
								rsp_nack <= ack_n;
								hst <= HS_WAIT;
							end
						end
					end
				end
				HS_PLOW: begin
					cnt <= cnt_inc;
					if (cnt == TWB_CNT_ZERO) begin
						sda_low <= 1'b1;
					end
					if (c_end) begin
						cnt <= TWB_CNT_ZERO;
						scl_low <= 1'b0;
						hst <= HS_PHIGH;
					end
				end
				HS_PHIGH: begin
					if (scl_s) begin
						cnt <= cnt_inc;
					end
					if (scl_s && c_end) begin
						cnt <= TWB_CNT_ZERO;
						sda_low <= 1'b0; // sda rises, scl high
						hst <= HS_PEND;
					end
				end
				HS_PEND: begin
					cnt <= cnt_inc;
					if (c_end) begin
						own <= 1'b0;
						rsp_valid <= 1'b1;
						rsp_nack <= 1'b0;
						hst <= HS_WAIT;
					end
				end
				HS_LOST: begin
					scl_low <= 1'b0;
					own <= 1'b0;
					if (!bus_busy) begin // wait for the winner's stop
						rsp_valid <= 1'b1;
						rsp_nack <= 1'b1;
						hst <= HS_WAIT;
					end
				end
				default: begin
					hst <= HS_WAIT;
				end
			endcase
		end
	end
endmodule // twb_host_end

// ---- verification/twb_bus_props.sv ----
`timescale 1ns/1ns
module twb_bus_props (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic dev_scl_o,
	input wire logic dev_scl_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic host_scl_o,
	input wire logic host_scl_oe,
	input wire logic host_sda_o,
	input wire logic host_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	// ****************************************
	// line events seen from the user clock
	// ****************************************
	default clocking bus_cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	// data edges while the clock line stays high
	sequence start_seen;
		scl && $past(scl) && $fell(sda);
	endsequence
	sequence stop_seen;
		scl && $past(scl) && $rose(sda);
	endsequence
	sequence clock_drops;
		##[1:60] !scl;
	endsequence

	// ****************************************
	// checks
	// ****************************************
	chk_dev_open_drain: assert property (!dev_scl_o && !dev_sda_o && (!dev_sda_oe || !sda)
		&& (!dev_scl_oe || !scl))
		else $error("device end drives a line high");
	chk_host_open_drain: assert property (!host_scl_o && !host_sda_o && (!host_sda_oe || !sda)
		&& (!host_scl_oe || !scl))
		else $error("host end drives a line high");
	chk_start_then_clock: assert property (start_seen |-> clock_drops)
		else $error("no clock low after start");
	chk_stop_leaves_idle: assert property (stop_seen |-> (scl && sda) [*2])
		else $error("lines not idle after stop");
	chk_sda_hold_high: assert property ($rose(scl) |->
		($stable(dev_sda_oe) && $stable(host_sda_oe)) [*6])
		else $error("data changed in clock high phase");
	chk_stretch_after_low: assert property ($rose(dev_scl_oe) |->
		!$past(scl) && !$past(scl, 2))
		else $error("device pulled clock while it was high");
	chk_stretch_bounded: assert property ($rose(dev_scl_oe) |-> ##[1:300] !dev_scl_oe)
		else $error("device stretch too long");
	chk_host_waits_release: assert property (!host_scl_oe && !scl |=> !host_scl_oe)
		else $error("host clocked while line held low");
	chk_addr_phase_quiet: assert property (start_seen |->
		(!dev_sda_oe && !dev_scl_oe) [*8])
		else $error("device drove lines right after start");
endmodule // twb_bus_props

// ---- verification/two_wire_bus_protocol_test.sv ----
`timescale 1ns/1ns
module two_wire_bus_protocol_test
	import twb_pkg::*;
;
	logic clk, link_clk, rst_b, cmd_valid, cmd_ready, cmd_last, rsp_valid, rsp_nack;
	logic rsp_arb_lost, bus_busy, slv_rx_valid, slv_tx_need, slv_tx_valid, mst_start;
	logic mst_busy, mst_done, mst_nack, mst_arb_lost, bench_sda_oe, tx_idx;
	logic [7:0] cmd_data, rsp_data, slv_rx_data, slv_tx_data, mst_data, rx_seen;
	logic [7:0] tx_tab [0:1] = '{8'hc3, 8'h81};
	logic [6:0] mst_addr;
	logic [9:0] wire_bits;
	twb_op_t cmd_op;
	int wire_cnt, mismatches, n_tests;
	twb_bus_if bus_a();
	twb_bus_if bus_b();

	// ****************************************
	// ends under test and bench master on second bus
	// ****************************************
	twb_host_end #(.HALF(10)) u_twb_host_end (.clk(clk), .rst_b(rst_b), .bus(bus_a.host),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data),
		.cmd_last(cmd_last), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack),
		.rsp_arb_lost(rsp_arb_lost), .bus_busy(bus_busy));
	twb_dev_end #(.HALF(4)) u_twb_dev_end (.clk(clk), .rst_b(rst_b), .link_clk(link_clk),
		.bus(bus_a.dev), .slv_rx_data(slv_rx_data), .slv_rx_valid(slv_rx_valid),
		.slv_tx_need(slv_tx_need), .slv_tx_data(slv_tx_data), .slv_tx_valid(slv_tx_valid),
		.mst_start(1'b0), .mst_addr(mst_addr), .mst_data(mst_data), .mst_busy(),
		.mst_done(), .mst_nack(), .mst_arb_lost());
	twb_dev_end #(.HALF(4)) u_twb_dev_end_b (.clk(clk), .rst_b(rst_b), .link_clk(link_clk),
		.bus(bus_b.dev), .slv_rx_data(), .slv_rx_valid(), .slv_tx_need(),
		.slv_tx_data(slv_tx_data), .slv_tx_valid(slv_tx_valid), .mst_start(mst_start),
		.mst_addr(mst_addr),
		.mst_data(mst_data), .mst_busy(mst_busy), .mst_done(mst_done), .mst_nack(mst_nack),
		.mst_arb_lost(mst_arb_lost));
	twb_bus_props u_twb_bus_props (.clk(clk), .rst_b(rst_b), .scl(bus_a.scl), .sda(bus_a.sda),
		.dev_scl_o(bus_a.dev_scl_o), .dev_scl_oe(bus_a.dev_scl_oe),
		.dev_sda_o(bus_a.dev_sda_o), .dev_sda_oe(bus_a.dev_sda_oe),
		.host_scl_o(bus_a.host_scl_o), .host_scl_oe(bus_a.host_scl_oe),
		.host_sda_o(bus_a.host_sda_o), .host_sda_oe(bus_a.host_sda_oe));
	// bench only pulls data low on the second bus
	assign bus_b.host_scl_o = 1'b0;
	assign bus_b.host_sda_o = 1'b0;
	assign bus_b.host_scl_oe = 1'b0;
	assign bus_b.host_sda_oe = bench_sda_oe;

	// clocks, link clock out of phase
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		link_clk = 1'b0;
		#7;
		forever #40 link_clk = ~link_clk;
	end

	// slave user side: read bytes from table, keep last written byte
	always @(posedge clk) begin
		slv_tx_valid <= slv_tx_need === 1'b1 && !slv_tx_valid;
		if (slv_tx_need === 1'b1 && !slv_tx_valid) begin
			slv_tx_data <= tx_tab[tx_idx];
			tx_idx <= ~tx_idx;
		end
		if (slv_rx_valid === 1'b1) begin
			rx_seen <= slv_rx_data;
		end
	end

	// wire monitor on second bus: bits per clock rise, count cleared at start
	always @(posedge bus_b.scl) begin
		wire_bits <= {wire_bits[8:0], bus_b.sda};
		wire_cnt <= wire_cnt + 1;
	end
	always @(negedge bus_b.sda) begin
		if (bus_b.scl === 1'b1) begin
			wire_cnt <= 0;
		end
	end

	// ****************************************
	// tasks
	// ****************************************
	task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	function automatic logic event_seen(input int what);
		case (what)
			0: return cmd_ready === 1'b1;
			1: return rsp_valid === 1'b1;
			2: return mst_done === 1'b1;
			3: return bus_b.sda === 1'b0;
			4: return bus_b.scl === 1'b0;
			default: return bus_b.scl === 1'b1;
		endcase
	endfunction

	// bounded wait on one of the events above
	task automatic wait_for(input int what);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (!event_seen(what) && n < 5000);
		if (!event_seen(what)) begin
			mismatches++;
			$display("wrong value wait %0d expected event seen none", what);
			test_done();
		end
	endtask

	// one host command: held until taken, then wait for the answer
	task automatic host_cmd(input twb_op_t op, input logic [7:0] d, input logic l);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_data <= d;
		cmd_last <= l;
		wait_for(0);
		@(posedge clk);
		cmd_valid <= 1'b0;
		wait_for(1);
	endtask

	task automatic pulse_start();
		@(posedge clk);
		mst_start <= 1'b1;
		@(posedge clk);
		mst_start <= 1'b0;
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{rst_b, cmd_valid, cmd_last, mst_start, bench_sda_oe, tx_idx, slv_tx_valid} = 7'h00;
		{cmd_data, slv_tx_data, rx_seen, mst_data} = {24'h00_0000, 8'h5a};
		cmd_op = TWB_OP_START;
		mst_addr = 7'h53;
		{wire_bits, wire_cnt, mismatches, n_tests} = '0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		repeat (12) @(posedge clk);
		host_cmd(TWB_OP_START, {TWB_SLV_ADDR0, 1'b0}, 1'b0);
		check("address ack", {9'h000, rsp_nack}, 10'h000);
		check("bus busy", {9'h000, bus_busy}, 10'h001);
		host_cmd(TWB_OP_WRITE, 8'ha5, 1'b0);
		check("write ack", {9'h000, rsp_nack}, 10'h000);
		check("host arb flag", {9'h000, rsp_arb_lost}, 10'h000);
		check("written byte", {2'b00, rx_seen}, 10'h0a5);
		host_cmd(TWB_OP_WRITE, 8'h3c, 1'b0);
		check("second byte", {2'b00, rx_seen}, 10'h03c);
		$display("test master write done");
		host_cmd(TWB_OP_START, {TWB_SLV_ADDR1, 1'b1}, 1'b0);
		check("repeated start ack", {9'h000, rsp_nack}, 10'h000);
		host_cmd(TWB_OP_READ, 8'h00, 1'b0);
		check("read byte", {2'b00, rsp_data}, 10'h0c3);
		host_cmd(TWB_OP_READ, 8'h00, 1'b1);
		check("last read byte", {2'b00, rsp_data}, 10'h081);
		host_cmd(TWB_OP_STOP, 8'h00, 1'b0);
		check("bus idle", {9'h000, bus_busy}, 10'h000);
		host_cmd(TWB_OP_WRITE, 8'hff, 1'b0);
		check("write without bus", {9'h000, rsp_nack}, 10'h001);
		$display("test combined read done");
		host_cmd(TWB_OP_START, 8'h22, 1'b0);
		check("foreign address", {9'h000, rsp_nack}, 10'h001);
		host_cmd(TWB_OP_STOP, 8'h00, 1'b0);
		$display("test foreign address done");
		pulse_start();
		wait_for(2);
		check("device nack", {9'h000, mst_nack}, 10'h001);
		check("clock rises", wire_cnt[9:0], 10'h00a);
		check("wire bits", wire_bits, {7'h53, 1'b0, 1'b1, 1'b0});
		$display("test device address only done");
		pulse_start();
		wait_for(3);
		wait_for(4);
		@(posedge clk);
		bench_sda_oe <= 1'b1;
		wait_for(5);
		repeat (40) begin
			@(negedge clk);
			check("loser lines", {8'h00, bus_b.dev_scl_oe, bus_b.dev_sda_oe}, 10'h000);
		end
		check("waits for stop", {9'h000, mst_busy}, 10'h001);
		@(posedge clk);
		bench_sda_oe <= 1'b0;
		wait_for(2);
		check("arbitration lost", {9'h000, mst_arb_lost}, 10'h001);
		$display("test arbitration done");
		test_done();
	end
endmodule // two_wire_bus_protocol_test
